// ### ssr_core.sv
// Purpose: Builds the open stream status reply, one 16-bit word per beat
// Assumes: Host side takes a word when out_valid and out_ready are both high
// Notes: Table writes during a reply do not disturb it; ids are snapshotted
`timescale 1ns/10ps
module ssr_core
  import ssr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic tbl_wr_en,
  input wire logic [SSR_IDX_W-1:0] tbl_wr_idx,
  input wire ssr_entry_t tbl_wr_entry,
  input wire logic req_valid,
  input wire ssr_req_t req,
  output logic req_ready,
  output logic out_valid,
  output logic [15:0] out_word,
  input wire logic out_ready,
  output logic busy,
  output logic done
);

  // ******************************************
  // Storage
  // ******************************************
  ssr_entry_t table_r [SSR_ENTRIES];
  logic [SSR_ENTRIES-1:0] snap_sel_r;
  logic [SSR_ENTRIES*16-1:0] snap_ids_r;
  ssr_state_t state_r;
  logic [15:0] count_r;
  logic [15:0] sent_r;
  logic [15:0] last_r;
  logic first_r;
  logic [16:0] remain_r;
  logic out_valid_r;
  logic [15:0] out_word_r;
  logic pad_r;
  logic req_ready_r;
  logic done_r;

  // ******************************************
  // Live selection and distinct count
  // ******************************************
  logic [SSR_ENTRIES-1:0] live_sel;
  logic [SSR_ENTRIES*16-1:0] live_ids;
  logic [SSR_ENTRIES*16-1:0] live_hosts;
  logic [15:0] live_count;
  logic accept;
  logic beat;
  logic last_beat;
  logic want_id;
  logic pick_found;
  logic [15:0] pick_id;

  // Directive specific field is never read by the selection
  genvar g;
  generate
    for (g = 0; g < SSR_ENTRIES; g++) begin : gen_sel
      assign live_sel[g] = ssr_match(table_r[g], req);
      assign live_ids[g*16 +: 16] = table_r[g].sid;
      assign live_hosts[g*16 +: 16] = table_r[g].host;
    end
  endgenerate

  // Count an id only at its first selected occurrence
  always_comb begin
    logic dup;
    live_count = SSR_CNT_ZERO;
    dup = 1'b0;
    for (int i = 0; i < SSR_ENTRIES; i++) begin
      dup = 1'b0;
      for (int j = 0; j < i; j++) begin
        if (live_sel[j] && table_r[j].sid == table_r[i].sid) begin
          dup = 1'b1;
        end
      end
      if (live_sel[i] && !dup) begin
        live_count = live_count + SSR_CNT_ONE;
      end
    end
  end

  assign accept = (state_r == SSR_IDLE) && req_valid;
  assign beat = out_valid_r && out_ready;
  assign last_beat = beat && (remain_r == SSR_LEN_ONE);
  assign want_id = (sent_r < count_r) && pick_found;

  // ******************************************
  // Next identifier from the snapshot
  // ******************************************
  ssr_pick u_pick (
    .sel(snap_sel_r),
    .ids(snap_ids_r),
    .thresh(last_r),
    .first(first_r),
    .found(pick_found),
    .pick(pick_id)
  );

  // ******************************************
  // Stream table
  // ******************************************
  // Written by the stream open and close logic elsewhere in the controller
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < SSR_ENTRIES; i++) begin
        table_r[i] <= '0;
      end
    end else if (tbl_wr_en) begin
      table_r[tbl_wr_idx] <= tbl_wr_entry;
    end
  end

  // Snapshot keeps a reply self-consistent while streams open or close
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      snap_sel_r <= '0;
      snap_ids_r <= '0;
    end else if (accept) begin
      snap_sel_r <= live_sel;
      snap_ids_r <= live_ids;
    end
  end

  // ******************************************
  // Reply sequencer
  // ******************************************
  ssr_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SSR_IDLE: begin
        if (accept && req.word_count != SSR_LEN_ZERO) begin
          state_nxt = SSR_SEND;
        end
      end
      SSR_SEND: begin
        if (last_beat) begin
          state_nxt = SSR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= SSR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Length clipped so the last slot never passes bytes 131071:131070
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      remain_r <= SSR_LEN_ZERO;
    end else if (accept) begin
      remain_r <= (req.word_count > SSR_MAX_WORDS) ? SSR_MAX_WORDS : req.word_count;
    end else if (beat) begin
      remain_r <= remain_r - SSR_LEN_ONE;
    end
  end

  // Head word is the count; each beat loads the following slot
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_word_r <= SSR_WORD_ZERO;
      out_valid_r <= 1'b0;
      pad_r <= 1'b0;
    end else if (accept) begin
      out_word_r <= live_count;
      out_valid_r <= (req.word_count != SSR_LEN_ZERO);
      pad_r <= 1'b0;
    end else if (last_beat) begin
      out_word_r <= SSR_WORD_ZERO;
      out_valid_r <= 1'b0;
      pad_r <= 1'b0;
    end else if (beat) begin
      out_word_r <= want_id ? pick_id : SSR_WORD_ZERO;
      pad_r <= !want_id;
    end
  end

  // Progress through the sorted list; threshold only moves upward
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_r <= SSR_CNT_ZERO;
      sent_r <= SSR_CNT_ZERO;
      last_r <= SSR_WORD_ZERO;
      first_r <= 1'b1;
    end else if (accept) begin
      count_r <= live_count;
      sent_r <= SSR_CNT_ZERO;
      last_r <= SSR_WORD_ZERO;
      first_r <= 1'b1;
    end else if (beat && !last_beat && want_id) begin
      sent_r <= sent_r + SSR_CNT_ONE;
      last_r <= pick_id;
      first_r <= 1'b0;
    end
  end

  // Handshake flags; done also fires for an empty-length request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      req_ready_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      req_ready_r <= (state_nxt == SSR_IDLE) && !accept;
      done_r <= last_beat || (accept && req.word_count == SSR_LEN_ZERO);
    end
  end

  assign req_ready = req_ready_r;
  assign out_valid = out_valid_r;
  assign out_word = out_word_r;
  assign busy = (state_r == SSR_SEND);
  assign done = done_r;

  // ******************************************
  // Checks
  // ******************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  function automatic logic any_lower(input logic [SSR_ENTRIES-1:0] s, input logic [SSR_ENTRIES*16-1:0] d,
                                     input logic [15:0] v);
    logic r;
    r = 1'b0;
    for (int i = 0; i < SSR_ENTRIES; i++) begin
      if (s[i] && d[i*16 +: 16] < v) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  // Hosts come in as an argument so the check sees sampled values, not the table after the edge
  function automatic logic any_foreign(input logic [SSR_ENTRIES-1:0] s, input logic [SSR_ENTRIES*16-1:0] hs,
                                       input logic [15:0] h);
    logic r;
    r = 1'b0;
    for (int i = 0; i < SSR_ENTRIES; i++) begin
      if (s[i] && (hs[i*16 +: 16] != h || hs[i*16 +: 16] == SSR_HOST_NONE)) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  sequence s_accept_long;
    accept && req.word_count != SSR_LEN_ZERO;
  endsequence

  sequence s_head_shown;
    out_valid_r && out_word_r == $past(live_count) && !pad_r;
  endsequence

  chk_head_count: assert property (s_accept_long |=> s_head_shown)
    else $error("head word is not the open count");

  chk_first_lowest: assert property (beat && !last_beat && first_r && want_id |=>
    !any_lower(snap_sel_r, snap_ids_r, out_word_r))
    else $error("first slot is not the smallest id");

  chk_ids_ascending: assert property (beat && !last_beat && !first_r && want_id |=> out_word_r > $past(last_r))
    else $error("identifier slots not strictly ascending");

  chk_no_dup_count: assert property (sent_r <= count_r)
    else $error("more ids sent than distinct open streams");

  chk_pad_zero: assert property (out_valid_r && pad_r |-> out_word_r == SSR_WORD_ZERO)
    else $error("slot past the count is not zero");

  chk_pad_sticks: assert property (out_valid_r && pad_r && beat && !last_beat |=> pad_r)
    else $error("id reappeared after padding began");

  chk_scope_local: assert property (accept && !req.subsystem_scope_select[SSR_SCOPE_BIT] |->
    !any_foreign(live_sel, live_hosts, req.host_id))
    else $error("foreign host stream selected in local scope");

  chk_len_bound: assert property (remain_r <= SSR_MAX_WORDS)
    else $error("reply longer than the slot table");

  chk_busy_refuse: assert property (state_r == SSR_SEND |-> !req_ready_r ##0 !accept)
    else $error("request taken while a reply is in flight");

endmodule

// ### ssr_host_model.sv
// Purpose: Host model that drains reply words from the status reply builder
// Assumes: A word is taken on a rising edge with out_valid and out_ready high
// Notes: Stalls at random while stall_en is set, so held words get exercised
`timescale 1ns/10ps
module ssr_host_model
  import ssr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic stall_en,
  input wire logic clr,
  input wire logic out_valid,
  input wire logic [15:0] out_word,
  output logic out_ready,
  output int n_got
);
  logic [15:0] got [0:65535];

  // ******************************
  // Ready drive and word capture
  // ******************************
  // Ready moves on the falling edge only, so it is steady when sampled
  always @(negedge ref_clk) begin
    out_ready <= reset ? 1'b0 : (stall_en ? 1'($urandom % 2) : 1'b1);
  end
  // Capture restarts with each request; no bound check, the reply caps itself
  always @(posedge ref_clk) begin
    if (reset || clr) begin
      n_got <= 0;
    end else if (out_valid && out_ready) begin
      got[n_got] <= out_word;
      n_got <= n_got + 1;
    end
  end
endmodule

// ### ssr_pick.sv
// Purpose: Finds the smallest selected stream id above a threshold
// Assumes: Inputs are a stable snapshot; purely combinational
// Notes: With first set, any selected id qualifies, so id zero is not lost
`timescale 1ns/10ps
module ssr_pick
  import ssr_pkg::*;
(
  input wire logic [SSR_ENTRIES-1:0] sel,
  input wire logic [SSR_ENTRIES*16-1:0] ids,
  input wire logic [15:0] thresh,
  input wire logic first,
  output logic found,
  output logic [15:0] pick
);

  // ******************************************
  // Minimum search
  // ******************************************
  // Linear scan; equal ids collapse since only the strictly greater ones count
  always_comb begin
    logic [15:0] cur;
    logic hit;
    found = 1'b0;
    pick = SSR_WORD_ZERO;
    cur = SSR_WORD_ZERO;
    hit = 1'b0;
    for (int i = 0; i < SSR_ENTRIES; i++) begin
      cur = ids[i*16 +: 16];
      hit = sel[i] && (first || cur > thresh);
      if (hit && (!found || cur < pick)) begin
        found = 1'b1;
        pick = cur;
      end
    end
  end

endmodule

// ### ssr_pkg.sv
// Purpose: Shared types and constants for the stream status reply builder
// Assumes: One 16-bit reply word per transfer, word 0 is the open count
// Notes: Stream table depth is a storage choice; the reply format is fixed
package ssr_pkg;

  // ******************************************
  // Table and reply geometry
  // ******************************************
  localparam int SSR_ENTRIES = 16;
  localparam int SSR_IDX_W = 4;
  localparam int SSR_CNT_W = 16;
  localparam int SSR_LEN_W = 17;
  // Count word plus 65535 identifier slots, bytes 131071:131070 are the last
  localparam logic [16:0] SSR_MAX_WORDS = 17'h10000;
  localparam logic [31:0] SSR_NS_ALL = 32'hffffffff;
  localparam int SSR_SCOPE_BIT = 0;
  localparam logic [15:0] SSR_WORD_ZERO = 16'h0000;
  localparam logic [15:0] SSR_CNT_ZERO = 16'h0000;
  localparam logic [15:0] SSR_CNT_ONE = 16'h0001;
  localparam logic [16:0] SSR_LEN_ONE = 17'h00001;
  localparam logic [16:0] SSR_LEN_ZERO = 17'h00000;
  localparam logic [15:0] SSR_HOST_NONE = 16'h0000;

  // One open stream as tracked by the controller
  typedef struct packed {
    logic valid;
    logic shared;
    logic [31:0] ns;
    logic [15:0] host;
    logic [15:0] sid;
  } ssr_entry_t;

  // One status request as decoded from the command
  typedef struct packed {
    logic [31:0] namespace_selector;
    logic [7:0] subsystem_scope_select;
    logic [15:0] directive_specific_field;
    logic [15:0] host_id;
    logic [16:0] word_count;
  } ssr_req_t;

  typedef enum logic [0:0] {
    SSR_IDLE = 1'b0,
    SSR_SEND = 1'b1
  } ssr_state_t;

  // Whether an entry belongs in the reply for this request
  function automatic logic ssr_match(input ssr_entry_t e, input ssr_req_t q);
    logic ns_ok;
    logic host_ok;
    ns_ok = (q.namespace_selector == SSR_NS_ALL) ? e.shared :
            (!e.shared && e.ns == q.namespace_selector);
    host_ok = q.subsystem_scope_select[SSR_SCOPE_BIT] ? (e.host != SSR_HOST_NONE) :
              (e.host != SSR_HOST_NONE && e.host == q.host_id);
    return e.valid && ns_ok && host_ok;
  endfunction

endpackage

// ### tb_top.sv
// Purpose: Self-checking bench for the stream status reply builder
// Assumes: Inputs driven on the falling edge; seed fixed for repeatable runs
// Notes: Expected replies come from a bench copy of the stream table
`timescale 1ns/10ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: %s", $time, m); end end
module tb_top;
  import ssr_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic tbl_wr_en = 1'b0;
  logic [3:0] tbl_wr_idx = 4'h0;
  ssr_entry_t tbl_wr_entry = '0;
  logic req_valid = 1'b0;
  ssr_req_t req = '0;
  logic req_ready, out_valid, out_ready, busy, done;
  logic [15:0] out_word;
  logic stall_en = 1'b0;
  logic clr = 1'b0;
  int n_got, err_total, checked, seed;
  ssr_entry_t tbl [SSR_ENTRIES];
  ssr_req_t q;

  // ******************************
  // Design, host model and clock
  // ******************************
  ssr_core ssr_core_inst (.ref_clk(ref_clk), .reset(reset), .tbl_wr_en(tbl_wr_en), .tbl_wr_idx(tbl_wr_idx),
    .tbl_wr_entry(tbl_wr_entry), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .out_valid(out_valid), .out_word(out_word), .out_ready(out_ready), .busy(busy), .done(done));
  ssr_host_model host (.ref_clk(ref_clk), .reset(reset), .stall_en(stall_en), .clr(clr),
    .out_valid(out_valid), .out_word(out_word), .out_ready(out_ready), .n_got(n_got));
  always #50 ref_clk = ~ref_clk;

  // ******************************
  // Expected reply
  // ******************************
  // Selection written out from the reply rules, independent of the design
  function automatic logic sel_ok(ssr_entry_t e, ssr_req_t r);
    logic ns_hit;
    logic host_hit;
    ns_hit = (r.namespace_selector === 32'hffffffff) ? e.shared : (!e.shared && e.ns === r.namespace_selector);
    host_hit = (e.host !== 16'h0000) && (r.subsystem_scope_select[0] || e.host === r.host_id);
    return e.valid && ns_hit && host_hit;
  endfunction
  // Word k of the reply: distinct ids found by repeated minimum search
  function automatic logic [15:0] exp_word(ssr_req_t r, int k);
    int n;
    int best;
    int prev;
    n = 0;
    prev = -1;
    for (int j = 0; j < SSR_ENTRIES; j++) begin
      best = 65536;
      for (int i = 0; i < SSR_ENTRIES; i++) begin
        if (sel_ok(tbl[i], r) && int'(tbl[i].sid) > prev && int'(tbl[i].sid) < best) best = tbl[i].sid;
      end
      if (best < 65536) begin
        n++;
        prev = best;
        if (n == k) return 16'(best);
      end
    end
    return (k == 0) ? 16'(n) : 16'h0000;
  endfunction

  // ******************************
  // Tasks
  // ******************************
  task automatic tally_and_finish();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr_entry(int idx, ssr_entry_t e);
    @(negedge ref_clk);
    tbl_wr_en = 1'b1;
    tbl_wr_idx = 4'(idx);
    tbl_wr_entry = e;
    tbl[idx] = e;
    @(negedge ref_clk);
    tbl_wr_en = 1'b0;
  endtask
  // One request, drained by the host model, then words 0 to 23 and the last word compared
  task automatic run_req(ssr_req_t r);
    int n;
    int t;
    n = (r.word_count > 17'h10000) ? 65536 : int'(r.word_count);
    @(negedge ref_clk);
    req = r;
    req_valid = 1'b1;
    clr = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    clr = 1'b0;
    `CHK(busy, (r.word_count != 17'h00000), "busy after take")
    `CHK(out_valid, (r.word_count != 17'h00000), "head word present")
    for (t = 0; t < 70000 && done !== 1'b1; t++) @(negedge ref_clk);
    if (t == 70000) begin
      err_total++;
      tally_and_finish();
    end
    `CHK(busy, 1'b0, "busy after done")
    `CHK(n_got, n, "reply length")
    if (n > 0) `CHK(host.got[0], exp_word(r, 0), "open count")
    if (n > 1) `CHK(host.got[1], exp_word(r, 1), "first id")
    for (int k = 2; k < n && k < 24; k++) `CHK(host.got[k], exp_word(r, k), "later slot")
    if (n > 24) `CHK(host.got[n-1], 16'h0000, "last slot")
  endtask

  // ******************************
  // Main sequence
  // ******************************
  initial begin
    err_total = 0;
    checked = 0;
    seed = $urandom(31);
    for (int i = 0; i < SSR_ENTRIES; i++) tbl[i] = '0;
    repeat (10) @(negedge ref_clk);
    `CHK(out_valid, 1'b0, "valid in reset")
    reset = 1'b0;
    @(negedge ref_clk);
    `CHK(req_ready, 1'b1, "ready after reset")
    // Corners: shared and private dups, host zero, closed entry, id 0 and ffff
    wr_entry(0, {1'b1, 1'b0, 32'h1, 16'h1, 16'h0007});
    wr_entry(1, {1'b1, 1'b0, 32'h2, 16'h1, 16'h0007});
    wr_entry(2, {1'b1, 1'b1, 32'h3, 16'h1, 16'h0007});
    wr_entry(3, {1'b1, 1'b1, 32'h4, 16'h2, 16'h0007});
    wr_entry(4, {1'b1, 1'b0, 32'h1, 16'h0, 16'h0003});
    wr_entry(5, {1'b1, 1'b0, 32'h1, 16'h2, 16'h0000});
    wr_entry(6, {1'b0, 1'b0, 32'h1, 16'h1, 16'h0001});
    wr_entry(7, {1'b1, 1'b0, 32'h1, 16'h1, 16'hffff});
    for (int m = 0; m < 4; m++) begin
      q = {m[1] ? 32'hffffffff : 32'h1, 8'(m[0]), 16'($urandom), 16'h1, 17'h0000c};
      run_req(q);
    end
    // Random table updates and requests, with host stalls
    for (int it = 0; it < 40; it++) begin
      repeat ($urandom % 3 + 1) wr_entry($urandom % 16, {1'($urandom % 4 != 0), 1'($urandom % 4 == 0),
        32'($urandom % 2 + 1), 16'($urandom % 3), 16'($urandom % 8)});
      stall_en = 1'($urandom % 2);
      q = {($urandom % 4 == 0) ? 32'hffffffff : 32'($urandom % 2 + 1), 8'($urandom), 16'($urandom),
        16'($urandom % 3), 17'($urandom % 20)};
      run_req(q);
    end
    // Oversized and zero-length requests
    stall_en = 1'b0;
    run_req({32'h1, 8'h01, 16'h0000, 16'h1, 17'h1ffff});
    run_req({32'h1, 8'h01, 16'h0000, 16'h1, 17'h00000});
    // Reset in mid-run, with a reply in flight and a refused request waiting
    @(negedge ref_clk);
    req = {32'h1, 8'h01, 16'h0000, 16'h1, 17'h00100};
    req_valid = 1'b1;
    @(negedge ref_clk);
    `CHK(busy, 1'b1, "busy in reply")
    repeat (3) @(negedge ref_clk);
    `CHK(req_ready, 1'b0, "ready while busy")
    reset = 1'b1;
    req_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK(busy, 1'b0, "busy in reset")
    `CHK(out_valid, 1'b0, "valid in mid-run reset")
    `CHK(out_word, 16'h0000, "word in mid-run reset")
    reset = 1'b0;
    for (int i = 0; i < SSR_ENTRIES; i++) tbl[i] = '0;
    @(negedge ref_clk);
    `CHK(req_ready, 1'b1, "ready after mid-run reset")
    `CHK(done, 1'b0, "no done after reset")
    run_req({32'hffffffff, 8'h01, 16'h0000, 16'h1, 17'h00003});
    tally_and_finish();
  end
endmodule
